// file: fcif_defines.svh
`ifndef FCIF_DEFINES_SVH
`define FCIF_DEFINES_SVH

// ----------------------------------------
// Register bus geometry
// ----------------------------------------
`define FCIF_ADDR_W 8
`define FCIF_DATA_W 32

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FCIF_OFS_FLAG_STATUS 8'h2C
`define FCIF_OFS_FLAG_SET 8'h30
`define FCIF_OFS_FLAG_CLEAR 8'h34
`define FCIF_OFS_ENABLE 8'h38
`define FCIF_OFS_OVR_STATUS 8'h40
`define FCIF_OFS_OVR_MASK 8'h44

// ----------------------------------------
// Field layout, shared by every register
// ----------------------------------------
`define FCIF_NFLAGS 2
`define FCIF_BIT_ERASE 0
`define FCIF_BIT_WRITE 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FCIF_RST_FLAGS 2'h0
`define FCIF_RST_DATA 32'h0

`endif

// file: fcif_flag_cell.sv
`timescale 1ns/10ps
`default_nettype none

// Sticky bit: any set source wins over a clear in the same cycle
module fcif_flag_cell (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic set_a,
	input wire logic set_b,
	input wire logic clr,
	output logic q
);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			q <= 1'b0;
		end else begin
			q <= (q & ~clr) | set_a | set_b;
		end
	end

endmodule

`default_nettype wire

// file: fcif_irq_gate.sv
`timescale 1ns/10ps
`default_nettype none

// Level request while any flag stands together with its enable
module fcif_irq_gate (
	input wire fcif_pkg::fcif_flags_t flags,
	input wire fcif_pkg::fcif_flags_t enable,
	output logic irq
);

	assign irq = |(flags & enable);

endmodule

`default_nettype wire

// file: fcif_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module fcif_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic write_done_pulse,
	input wire logic erase_done_pulse,
	input wire logic flash_irq,
	input wire logic ovr_irq
);
	// ----------------------------------------
	// Decoded accesses
	// ----------------------------------------
	logic rd_st;
	logic [1:0] set_w;
	logic [1:0] clr_w;
	assign rd_st = reg_rd && reg_addr == 8'h2C;
	assign set_w = {2{reg_wr && reg_addr == 8'h30}} & reg_wdata[1:0];
	// A completion pulse in the clear cycle wins, so leave those cases out
	assign clr_w = {2{reg_wr && reg_addr == 8'h34}} & reg_wdata[1:0]
		& ~{write_done_pulse, erase_done_pulse};

	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	wr_set_a: assert property (set_w[1] ##1 rd_st |=> reg_rdata[1])
		else $error("write flag not set");
	er_set_a: assert property (set_w[0] ##1 rd_st |=> reg_rdata[0])
		else $error("erase flag not set");
	wr_clr_a: assert property (clr_w[1] ##1 rd_st && !write_done_pulse |=> !reg_rdata[1])
		else $error("write flag not cleared");
	er_clr_a: assert property (clr_w[0] ##1 rd_st && !erase_done_pulse |=> !reg_rdata[0])
		else $error("erase flag not cleared");
	en_rw_a: assert property (reg_wr && reg_addr == 8'h38
		##1 reg_rd && reg_addr == 8'h38 |=> reg_rdata == {30'h0, $past(reg_wdata[1:0], 2)})
		else $error("enable readback wrong");
	hw_wr_a: assert property (write_done_pulse ##1 rd_st |=> reg_rdata[1])
		else $error("write completion lost");
	hw_er_a: assert property (erase_done_pulse ##1 rd_st |=> reg_rdata[0])
		else $error("erase completion lost");
	// The erase flag may hold the request up on its own when its enable is set
	irq_en_a: assert property (set_w[1] ##1 reg_rd && reg_addr == 8'h38
		|=> (!reg_rdata[1] || flash_irq) && (!flash_irq || reg_rdata[1:0] != 2'h0))
		else $error("request not gated by enable");
	zero_wr_a: assert property (reg_wr && reg_addr == 8'h30 && reg_wdata[1:0] == 2'h0
		&& !write_done_pulse && !erase_done_pulse |=> $stable(flash_irq))
		else $error("zero write changed request");
	rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not idle");
endmodule

bind fcif_top fcif_monitor i_fcif_monitor (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.write_done_pulse(write_done_pulse), .erase_done_pulse(erase_done_pulse),
	.flash_irq(flash_irq), .ovr_irq(ovr_irq));

`default_nettype wire

// file: fcif_pkg.sv
package fcif_pkg;

	// ----------------------------------------
	// Register selection
	// ----------------------------------------
	typedef enum logic [2:0] {
		FCIF_SEL_NONE,
		FCIF_SEL_FLAG_STATUS,
		FCIF_SEL_FLAG_SET,
		FCIF_SEL_FLAG_CLEAR,
		FCIF_SEL_ENABLE,
		FCIF_SEL_OVR_STATUS,
		FCIF_SEL_OVR_MASK
	} fcif_reg_sel_t;

	typedef logic [1:0] fcif_flags_t;

endpackage

// file: fcif_top.sv
// Operation
// RULE1: Writing one to set-register bit 1 raises write-done flag and requests interrupt.
// RULE2: Writing one to set-register bit 0 raises erase-done flag and requests interrupt.
// RULE3: Writing one to clear-register bit 1 clears write-done flag; reads zero.
// RULE4: Writing one to clear-register bit 0 clears erase-done flag; reads zero.
// RULE5: Enable bit 1 is read-write, resets zero, gates write-done onto request.
// RULE6: Enable bit 0 is read-write, resets zero, gates erase-done onto request.
// RULE7: Software writes zeros to unused upper bits of set, clear, enable.
// RULE8: Write-done flag, status bit 1, sets whenever a flash word write completes.
// RULE9: Erase-done flag, status bit 0, sets whenever a flash erase completes.
// RULE10: Request high while flag and enable both set; zero writes do nothing.
`include "fcif_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module fcif_top (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [`FCIF_ADDR_W-1:0] reg_addr,
	input wire logic [`FCIF_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`FCIF_DATA_W-1:0] reg_rdata,
	input wire logic write_done_pulse,
	input wire logic erase_done_pulse,
	output logic flash_irq,
	output logic ovr_irq
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic fcif_pkg::fcif_reg_sel_t decode(input logic [`FCIF_ADDR_W-1:0] a);
		fcif_pkg::fcif_reg_sel_t s;
		s = fcif_pkg::FCIF_SEL_NONE;
		unique case (a)
			`FCIF_OFS_FLAG_STATUS: s = fcif_pkg::FCIF_SEL_FLAG_STATUS;
			`FCIF_OFS_FLAG_SET: s = fcif_pkg::FCIF_SEL_FLAG_SET;
			`FCIF_OFS_FLAG_CLEAR: s = fcif_pkg::FCIF_SEL_FLAG_CLEAR;
			`FCIF_OFS_ENABLE: s = fcif_pkg::FCIF_SEL_ENABLE;
			`FCIF_OFS_OVR_STATUS: s = fcif_pkg::FCIF_SEL_OVR_STATUS;
			`FCIF_OFS_OVR_MASK: s = fcif_pkg::FCIF_SEL_OVR_MASK;
			default: s = fcif_pkg::FCIF_SEL_NONE;
		endcase
		return s;
	endfunction

	fcif_pkg::fcif_reg_sel_t sel;
	assign sel = decode(reg_addr);

	// Upper data bits are ignored on every write, so stray ones there are harmless
	fcif_pkg::fcif_flags_t wr_bits;
	assign wr_bits = reg_wdata[`FCIF_NFLAGS-1:0]; // RULE7

	// ----------------------------------------
	// Write strobes per register
	// ----------------------------------------
	fcif_pkg::fcif_flags_t sw_set;
	fcif_pkg::fcif_flags_t sw_clr;
	fcif_pkg::fcif_flags_t hw_set;
	logic wr_enable;
	logic wr_ovr_mask;
	logic rd_ovr_status;

	// A zero bit in the written word selects nothing, so zero writes to the set and clear registers have no effect
	assign sw_set = (reg_wr && sel == fcif_pkg::FCIF_SEL_FLAG_SET) ? wr_bits
		: `FCIF_RST_FLAGS; // RULE1 RULE2 RULE10
	assign sw_clr = (reg_wr && sel == fcif_pkg::FCIF_SEL_FLAG_CLEAR) ? wr_bits
		: `FCIF_RST_FLAGS; // RULE3 RULE4 RULE10
	assign wr_enable = reg_wr && sel == fcif_pkg::FCIF_SEL_ENABLE;
	assign wr_ovr_mask = reg_wr && sel == fcif_pkg::FCIF_SEL_OVR_MASK;
	assign rd_ovr_status = reg_rd && sel == fcif_pkg::FCIF_SEL_OVR_STATUS;

	// The sequencer runs on this clock, so its completion pulses need no synchroniser
	always_comb begin
		hw_set = `FCIF_RST_FLAGS;
		hw_set[`FCIF_BIT_WRITE] = write_done_pulse; // RULE8
		hw_set[`FCIF_BIT_ERASE] = erase_done_pulse; // RULE9
	end

	// ----------------------------------------
	// Interrupt flags
	// ----------------------------------------
	fcif_pkg::fcif_flags_t flags;

	// A completion in the same cycle as a clear keeps the flag set
	genvar gi;
	generate
		for (gi = 0; gi < `FCIF_NFLAGS; gi++) begin : g_flag
			fcif_flag_cell u_flag (
				.clk_sys(clk_sys),
				.rst(rst),
				.set_a(hw_set[gi]),
				.set_b(sw_set[gi]),
				.clr(sw_clr[gi]),
				.q(flags[gi])
			); // RULE1 RULE2 RULE3 RULE4 RULE8 RULE9
		end
	endgenerate

	// ----------------------------------------
	// Interrupt enable
	// ----------------------------------------
	fcif_pkg::fcif_flags_t enable;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			enable <= `FCIF_RST_FLAGS; // RULE5 RULE6
		end else if (wr_enable) begin
			enable <= wr_bits; // RULE5 RULE6
		end
	end

	fcif_irq_gate u_flash_gate (
		.flags(flags),
		.enable(enable),
		.irq(flash_irq)
	); // RULE10

	// ----------------------------------------
	// Overrun events
	// ----------------------------------------
	// A raise that finds its flag already standing means software missed one
	// completion; that is logged here since the flag itself cannot count.
	fcif_pkg::fcif_flags_t ovr_event;
	fcif_pkg::fcif_flags_t ovr_status;
	fcif_pkg::fcif_flags_t ovr_mask;

	assign ovr_event = (hw_set | sw_set) & flags & ~sw_clr;

	generate
		for (gi = 0; gi < `FCIF_NFLAGS; gi++) begin : g_ovr
			fcif_flag_cell u_ovr (
				.clk_sys(clk_sys),
				.rst(rst),
				.set_a(ovr_event[gi]),
				.set_b(1'b0),
				.clr(rd_ovr_status),
				.q(ovr_status[gi])
			);
		end
	endgenerate

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ovr_mask <= `FCIF_RST_FLAGS;
		end else if (wr_ovr_mask) begin
			ovr_mask <= wr_bits;
		end
	end

	fcif_irq_gate u_ovr_gate (
		.flags(ovr_status),
		.enable(ovr_mask),
		.irq(ovr_irq)
	);

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Data stands for exactly the cycle after the read strobe, zero otherwise.
	// Set and clear registers are write-only and read as zero.
	logic [`FCIF_DATA_W-1:0] next_rdata;

	always_comb begin
		next_rdata = `FCIF_RST_DATA;
		if (reg_rd) begin
			unique case (sel)
				fcif_pkg::FCIF_SEL_FLAG_STATUS: next_rdata[`FCIF_NFLAGS-1:0] = flags;
				fcif_pkg::FCIF_SEL_ENABLE: next_rdata[`FCIF_NFLAGS-1:0] = enable;
				fcif_pkg::FCIF_SEL_OVR_STATUS: next_rdata[`FCIF_NFLAGS-1:0] = ovr_status;
				fcif_pkg::FCIF_SEL_OVR_MASK: next_rdata[`FCIF_NFLAGS-1:0] = ovr_mask;
				fcif_pkg::FCIF_SEL_FLAG_SET,
				fcif_pkg::FCIF_SEL_FLAG_CLEAR,
				fcif_pkg::FCIF_SEL_NONE: next_rdata = `FCIF_RST_DATA; // RULE3 RULE4
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= `FCIF_RST_DATA;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("Error %0t: got %h exp %h", $time, a, e); end end

module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic write_done_pulse = 1'b0;
	logic erase_done_pulse = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic flash_irq;
	logic ovr_irq;
	int num_errors = 0;
	int num_checks = 0;

	fcif_top i_fcif_top (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.write_done_pulse(write_done_pulse), .erase_done_pulse(erase_done_pulse),
		.flash_irq(flash_irq), .ovr_irq(ovr_irq));

	initial forever #2 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Bus and pin tasks, each entered just after a rising edge
	// ----------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look mid-cycle
	task rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		`CHK(reg_rdata, e)
		@(posedge clk_sys);
	endtask

	task irq(input logic f, input logic o);
		@(negedge clk_sys);
		`CHK(flash_irq, f)
		`CHK(ovr_irq, o)
		@(posedge clk_sys);
	endtask

	task pulse(input logic w, input logic e);
		write_done_pulse <= w;
		erase_done_pulse <= e;
		@(posedge clk_sys);
		write_done_pulse <= 1'b0;
		erase_done_pulse <= 1'b0;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd(8'h2C, 32'h0);
		rd(8'h38, 32'h0);
		rd(8'h30, 32'h0);
		rd(8'h34, 32'h0);
		irq(1'b0, 1'b0);
	endtask

	task t_soft;
		logic [1:0] m;
		for (int b = 0; b < 2; b++) begin
			m = 2'h1 << b;
			wr(8'h38, {30'h0, m});
			rd(8'h38, {30'h0, m});
			wr(8'h30, {30'h0, m});
			rd(8'h38, {30'h0, m});
			irq(1'b1, 1'b0);
			wr(8'h30, {30'h0, m});
			rd(8'h2C, {30'h0, m});
			rd(8'h40, {30'h0, m});
			wr(8'h34, 32'h0);
			rd(8'h2C, {30'h0, m});
			wr(8'h30, 32'h0);
			rd(8'h2C, {30'h0, m});
			wr(8'h38, 32'h0);
			irq(1'b0, 1'b0);
			wr(8'h34, {30'h0, m});
			rd(8'h2C, 32'h0);
		end
	endtask

	// Completion pulses, overrun interrupt, and an unmapped offset
	task t_hw;
		pulse(1'b1, 1'b0);
		@(posedge clk_sys);
		pulse(1'b1, 1'b0);
		rd(8'h2C, 32'h2);
		pulse(1'b0, 1'b1);
		rd(8'h2C, 32'h3);
		wr(8'h44, 32'h3);
		rd(8'h44, 32'h3);
		irq(1'b0, 1'b1);
		rd(8'h40, 32'h2);
		irq(1'b0, 1'b0);
		wr(8'h34, 32'h3);
		rd(8'h2C, 32'h0);
		wr(8'h3C, 32'h3);
		rd(8'h3C, 32'h0);
		// A completion in the clear cycle must survive the clear
		write_done_pulse <= 1'b1;
		wr(8'h34, 32'h3);
		write_done_pulse <= 1'b0;
		rd(8'h2C, 32'h2);
		wr(8'h34, 32'h3);
		rd(8'h2C, 32'h0);
	endtask

	task stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_reset;
		t_soft;
		t_hw;
		stop_test;
	end

	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		stop_test;
	end
endmodule

`default_nettype wire
